// ### pkg/can_mode_pkg.sv
// shared constants and types for the can controller mode and power control
// Functional notes
// - listen-only receives frames, drives only recessive
// - listen-only never transmits, dominant looped internally
// - loopback feeds transmitter output to receiver
// - loopback ignores rx pin, tx pin recessive
// - loopback ignores ack slot, raises both interrupts
// - controller_on_bit low stops all controller clocks
// - sleep stops clocks except register access
// - wait with wait_stop_select gives power-down, restart
// - deep stop modes always give power-down; a held init_request makes the controller alternate between init and power-down instead
// - light stop: sleep if acked, else power-down
// - wakeup irq needs request, ack, enables all set
// - sleep after tx drain, rx idle, and delay
// - sleep_ack set once sleep active, handshake
// - bus-off counting paused in sleep, tx recessive
// - sleep keeps buffers readable, defers moves, aborts
// - no wakeup_enable masks rx, locks sleep
// - wake on bus activity or request cleared
// - after wake wait 11 recessive bits
// - on wake perform deferred moves, aborts, transmissions
// - init aborts traffic, tx recessive at once
// - init stops controller, resets control and flags
// - init request synchronised, ack when all initialised
// - power-down stops traffic, recovery if not asleep
package can_mode_pkg;
	// controller operating mode
	typedef enum logic [2:0] {
		MODE_DISABLED = 3'b000,
		MODE_NORMAL = 3'b001,
		MODE_SLEEP_PEND = 3'b010,
		MODE_SLEEP = 3'b011,
		MODE_INIT = 3'b100,
		MODE_POWER_DOWN = 3'b101,
		MODE_RECOVER = 3'b110,
		MODE_WAKE_SYNC = 3'b111
	} can_mode_t;
	// cpu power state
	typedef enum logic [1:0] {
		CPU_RUN = 2'b00,
		CPU_WAIT = 2'b01,
		CPU_STOP3 = 2'b10,
		CPU_STOP12 = 2'b11
	} cpu_mode_t;
	localparam logic [3:0] RECESSIVE_RUN_BITS = 4'hb;
	localparam logic [7:0] BUSOFF_RUNS = 8'h80;
	localparam logic [3:0] SLEEP_SYNC_CYCLES = 4'h3;
	localparam logic [3:0] INIT_SYNC_CYCLES = 4'h3;
	localparam logic [3:0] RECOVERY_CYCLES = 4'h8;
	localparam logic [7:0] BIT_DIV_RESET = 8'h19;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_WIDTH = 8;
endpackage : can_mode_pkg

// ### pkg/can_link_if.sv
// link between can controller end and the cpu side end
interface can_link_if;
	logic controller_on_bit;
	logic wait_stop_select;
	logic sleep_request;
	logic wakeup_enable;
	logic wakeup_irq_enable;
	logic init_request;
	logic listen_only;
	logic loopback;
	logic [1:0] cpu_mode;
	logic sleep_ack;
	logic init_ack;
	logic wakeup_irq;
	logic tx_irq;
	logic rx_irq;
	logic [2:0] mode;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ready;
	modport ctrl (input controller_on_bit, wait_stop_select, sleep_request, wakeup_enable,
		wakeup_irq_enable, init_request, listen_only, loopback, cpu_mode, tx_data, tx_valid, rx_ready,
		output sleep_ack, init_ack, wakeup_irq, tx_irq, rx_irq, mode, tx_ready, rx_data, rx_valid);
	modport cpu (output controller_on_bit, wait_stop_select, sleep_request, wakeup_enable,
		wakeup_irq_enable, init_request, listen_only, loopback, cpu_mode, tx_data, tx_valid, rx_ready,
		input sleep_ack, init_ack, wakeup_irq, tx_irq, rx_irq, mode, tx_ready, rx_data, rx_valid);
endinterface : can_link_if

// ### hw/can_fifo.sv
// parameterised valid/ready fifo for the data path
module can_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic flush_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic push;
	logic pop;
	// full and empty from pointer wrap bit
	assign in_ready_out = !((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
	assign out_valid_out = (wr_ptr_r != rd_ptr_r);
	assign out_data_out = mem[rd_ptr_r[AW-1:0]];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	// storage write
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data_in;
		end
	end
	// pointers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || flush_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule // can_fifo

// ### hw/can_mode_ctrl.sv
// can controller end: mode, sleep, init and power-down control with pins
module can_mode_ctrl
	import can_mode_pkg::*;
#(
	parameter logic [7:0] BIT_DIV = BIT_DIV_RESET
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	can_link_if.ctrl link,
	input wire logic rx_pin_in,
	output logic tx_pin_out,
	input wire logic tx_pending_in,
	input wire logic rx_active_in,
	input wire logic bus_off_in,
	output logic clk_gate_out,
	output logic busoff_run_done_out
);
	can_mode_t mode_r;
	logic rx_s1_r;
	logic rx_s2_r;
	logic bit_en_r;
	logic [7:0] div_r;
	logic [3:0] dly_r;
	logic [3:0] rec_run_r;
	logic [7:0] busoff_cnt_r;
	logic was_asleep_r;
	logic rx_int;
	logic tx_bit;
	logic wake_evt;
	logic pd_req;
	logic tx_pin_r;
	logic sleep_ack_r;
	logic init_ack_r;
	logic wake_irq_r;
	logic tx_irq_r;
	logic rx_irq_r;
	logic clk_gate_r;
	logic fifo_flush;
	logic tx_f_valid;
	logic [7:0] tx_f_data;
	logic tx_take;
	logic rx_f_ready;
	// rx pin synchroniser
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_pin_in;
			rx_s2_r <= rx_s1_r;
		end
	end
	// bit-time enable divider
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || div_r == BIT_DIV) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			bit_en_r <= 1'b0;
		end else begin
			bit_en_r <= (div_r == BIT_DIV);
		end
	end
	// internal tx bit and receive path selection
	assign tx_bit = tx_f_valid ? tx_f_data[0] : 1'b1;
	always_comb begin
		if (link.loopback) begin
			rx_int = tx_bit;
		end else if (mode_r == MODE_SLEEP && !link.wakeup_enable) begin
			rx_int = 1'b1;
		end else if (link.listen_only) begin
			rx_int = rx_s2_r & tx_bit;
		end else begin
			rx_int = rx_s2_r & tx_bit;
		end
	end
	assign wake_evt = (mode_r == MODE_SLEEP) && link.wakeup_enable && !rx_s2_r;
	// power-down request from cpu mode
	always_comb begin
		unique case (cpu_mode_t'(link.cpu_mode))
			CPU_RUN: pd_req = 1'b0;
			CPU_WAIT: pd_req = link.wait_stop_select;
			CPU_STOP3: pd_req = !(link.sleep_request && sleep_ack_r);
			CPU_STOP12: pd_req = 1'b1;
		endcase
	end
	// mode state machine
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mode_r <= MODE_DISABLED;
		end else if (!link.controller_on_bit) begin
			mode_r <= MODE_DISABLED;
		end else if (link.init_request && mode_r != MODE_INIT) begin
			mode_r <= MODE_INIT;
		end else if (pd_req && mode_r != MODE_POWER_DOWN && mode_r != MODE_SLEEP) begin
			mode_r <= MODE_POWER_DOWN;
		end else begin
			unique case (mode_r)
				MODE_DISABLED: mode_r <= MODE_INIT;
				MODE_NORMAL: if (link.sleep_request) mode_r <= MODE_SLEEP_PEND;
				MODE_SLEEP_PEND: if (!tx_pending_in && !rx_active_in && dly_r == 4'h0)
					mode_r <= MODE_SLEEP;
				MODE_SLEEP: if (pd_req) mode_r <= MODE_POWER_DOWN;
					else if (wake_evt || !link.sleep_request) mode_r <= MODE_WAKE_SYNC;
				MODE_INIT: if (!link.init_request && init_ack_r) mode_r <= MODE_WAKE_SYNC;
				MODE_POWER_DOWN: if (!pd_req) mode_r <= was_asleep_r ? MODE_SLEEP : MODE_RECOVER;
				MODE_RECOVER: if (dly_r == 4'h0) mode_r <= MODE_WAKE_SYNC;
				MODE_WAKE_SYNC: if (rec_run_r == RECESSIVE_RUN_BITS) mode_r <= MODE_NORMAL;
			endcase
		end
	end
	// remember whether sleep preceded power-down
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			was_asleep_r <= 1'b0;
		end else if (mode_r != MODE_POWER_DOWN) begin
			was_asleep_r <= (mode_r == MODE_SLEEP);
		end
	end
	// delay counter for sleep sync and recovery
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			dly_r <= 4'h0;
		end else if (mode_r != MODE_INIT && link.init_request && link.controller_on_bit) begin
			dly_r <= INIT_SYNC_CYCLES;
		end else if (mode_r == MODE_NORMAL) begin
			dly_r <= SLEEP_SYNC_CYCLES;
		end else if (mode_r == MODE_POWER_DOWN) begin
			dly_r <= RECOVERY_CYCLES;
		end else if (dly_r != 4'h0) begin
			dly_r <= dly_r - 4'h1;
		end
	end
	// recessive run counter for resync and bus-off
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || mode_r == MODE_SLEEP || mode_r == MODE_INIT) begin
			rec_run_r <= 4'h0;
		end else if (bit_en_r) begin
			if (!rx_int) begin
				rec_run_r <= 4'h0;
			end else if (rec_run_r != RECESSIVE_RUN_BITS) begin
				rec_run_r <= rec_run_r + 4'h1;
			end else begin
				rec_run_r <= 4'h1;
			end
		end
	end
	// bus-off run counter, paused while asleep
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !bus_off_in || mode_r == MODE_INIT) begin
			busoff_cnt_r <= 8'h00;
		end else if (mode_r != MODE_SLEEP && mode_r != MODE_POWER_DOWN && bit_en_r && rx_int
			&& rec_run_r == RECESSIVE_RUN_BITS - 4'h1 && busoff_cnt_r != BUSOFF_RUNS) begin
			busoff_cnt_r <= busoff_cnt_r + 8'h01;
		end
	end
	// tx pin: recessive unless normal or sleep-pending and not listen-only, loopback or bus-off
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_pin_r <= 1'b1;
		end else if (mode_r != MODE_NORMAL && mode_r != MODE_SLEEP_PEND) begin
			tx_pin_r <= 1'b1;
		end else if (link.listen_only || link.loopback || bus_off_in) begin
			tx_pin_r <= 1'b1;
		end else begin
			tx_pin_r <= tx_bit;
		end
	end
	// handshake acknowledges, read only to the cpu side
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sleep_ack_r <= 1'b0;
			init_ack_r <= 1'b0;
		end else begin
			sleep_ack_r <= (mode_r == MODE_SLEEP) || (mode_r == MODE_POWER_DOWN && was_asleep_r);
			init_ack_r <= (mode_r == MODE_INIT) && (dly_r == 4'h0 || init_ack_r) && link.init_request;
		end
	end
	// interrupts and clock gate
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			wake_irq_r <= 1'b0;
			tx_irq_r <= 1'b0;
			rx_irq_r <= 1'b0;
			clk_gate_r <= 1'b0;
			busoff_run_done_out <= 1'b0;
		end else begin
			wake_irq_r <= wake_evt && link.sleep_request && sleep_ack_r && link.wakeup_irq_enable;
			tx_irq_r <= tx_take;
			rx_irq_r <= link.loopback && tx_take;
			clk_gate_r <= (mode_r == MODE_NORMAL || mode_r == MODE_SLEEP_PEND || mode_r == MODE_WAKE_SYNC
				|| mode_r == MODE_RECOVER);
			busoff_run_done_out <= (busoff_cnt_r == BUSOFF_RUNS);
		end
	end
	// data path: transmit only when online and not listen-only; rx held in sleep
	assign fifo_flush = (mode_r == MODE_INIT);
	assign tx_take = tx_f_valid && bit_en_r && mode_r == MODE_NORMAL && !link.listen_only;
	assign rx_f_ready = (mode_r != MODE_SLEEP) && (mode_r != MODE_POWER_DOWN) && link.rx_ready;
	can_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.flush_in(fifo_flush),
		.in_data_in(link.tx_data),
		.in_valid_in(link.tx_valid),
		.in_ready_out(link.tx_ready),
		.out_data_out(tx_f_data),
		.out_valid_out(tx_f_valid),
		.out_ready_in(tx_take)
	);
	// loopback frames return to receive side; ack slot not checked
	can_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.flush_in(fifo_flush),
		.in_data_in(tx_f_data),
		.in_valid_in(link.loopback && tx_take),
		.in_ready_out(),
		.out_data_out(link.rx_data),
		.out_valid_out(link.rx_valid),
		.out_ready_in(rx_f_ready)
	);
	assign tx_pin_out = tx_pin_r;
	assign clk_gate_out = clk_gate_r;
	assign link.mode = mode_r;
	assign link.sleep_ack = sleep_ack_r;
	assign link.init_ack = init_ack_r;
	assign link.wakeup_irq = wake_irq_r;
	assign link.tx_irq = tx_irq_r;
	assign link.rx_irq = rx_irq_r;
endmodule // can_mode_ctrl

// ### hw/can_cpu_side.sv
// cpu end: holds control bits and obeys sleep and init handshakes
module can_cpu_side
	import can_mode_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	can_link_if.cpu link,
	input wire logic enable_in,
	input wire logic wait_stop_select_in,
	input wire logic sleep_req_in,
	input wire logic wakeup_enable_in,
	input wire logic wakeup_irq_enable_in,
	input wire logic init_req_in,
	input wire logic listen_only_in,
	input wire logic loopback_in,
	input wire logic [1:0] cpu_mode_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	output logic sleep_ack_out,
	output logic init_ack_out
);
	logic on_r;
	logic slp_r;
	logic init_r;
	logic [7:0] rx_data_r;
	logic rx_valid_r;
	// control bits; requests dropped only after ack
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			on_r <= 1'b0;
			slp_r <= 1'b0;
			init_r <= 1'b1;
		end else begin
			on_r <= on_r | enable_in;
			if (sleep_req_in || link.sleep_ack) slp_r <= sleep_req_in;
			if (init_req_in || link.init_ack) init_r <= init_req_in;
		end
	end
	// capture received words
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_data_r <= 8'h00;
			rx_valid_r <= 1'b0;
			sleep_ack_out <= 1'b0;
			init_ack_out <= 1'b0;
			tx_ready_out <= 1'b0;
		end else begin
			rx_valid_r <= link.rx_valid;
			if (link.rx_valid) rx_data_r <= link.rx_data;
			sleep_ack_out <= link.sleep_ack;
			init_ack_out <= link.init_ack;
			tx_ready_out <= link.tx_ready;
		end
	end
	assign link.controller_on_bit = on_r;
	assign link.wait_stop_select = wait_stop_select_in;
	assign link.sleep_request = slp_r;
	assign link.wakeup_enable = wakeup_enable_in;
	assign link.wakeup_irq_enable = wakeup_irq_enable_in;
	assign link.init_request = init_r;
	assign link.listen_only = listen_only_in;
	assign link.loopback = loopback_in;
	assign link.cpu_mode = cpu_mode_in;
	assign link.tx_data = tx_data_in;
	assign link.tx_valid = tx_valid_in;
	assign link.rx_ready = 1'b1;
	assign rx_data_out = rx_data_r;
	assign rx_valid_out = rx_valid_r;
endmodule // can_cpu_side

// ### bench/can_mode_sva.sv
// link assertions for the two ends of the can mode and power control
module can_mode_sva
	import can_mode_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic controller_on_bit,
	input wire logic wait_stop_select,
	input wire logic sleep_request,
	input wire logic sleep_ack,
	input wire logic wakeup_enable,
	input wire logic wakeup_irq_enable,
	input wire logic wakeup_irq,
	input wire logic init_request,
	input wire logic init_ack,
	input wire logic listen_only,
	input wire logic loopback,
	input wire logic [1:0] cpu_mode,
	input wire logic [2:0] mode,
	input wire logic tx_pin_out,
	input wire logic clk_gate_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// acknowledges rise only out of their own modes
	a_sleep_ack_mode: assert property ($rose(sleep_ack) |-> $past(mode) == MODE_SLEEP) else $error("sleep ack early");
	a_init_ack_mode: assert property ($rose(init_ack) |-> $past(mode) == MODE_INIT) else $error("init ack early");
	a_init_req_hold: assert property ($fell(init_request) |-> $past(init_ack)) else $error("init request dropped");
	a_init_ack_delay: assert property ($rose(init_ack) |-> $past(mode, 4) == MODE_INIT) else $error("init ack too soon");
	// tx pin stays recessive in quiet modes
	a_init_tx_idle: assert property (mode == MODE_INIT && $past(mode) == MODE_INIT |-> tx_pin_out) else $error("tx in init");
	a_pd_tx_idle: assert property (mode == MODE_POWER_DOWN && $past(mode) == MODE_POWER_DOWN |-> tx_pin_out) else $error("tx pd");
	a_listen_tx_idle: assert property (listen_only && $past(listen_only) |-> tx_pin_out) else $error("tx in listen");
	a_loop_tx_idle: assert property (loopback && $past(loopback) |-> tx_pin_out) else $error("tx in loopback");
	// wake interrupt needs all four bits
	a_wake_irq_cause: assert property (wakeup_irq |-> $past(sleep_request && sleep_ack && wakeup_enable && wakeup_irq_enable))
		else $error("wake irq uncaused");
	// core clocks gated off
	a_sleep_gate_off: assert property (mode == MODE_SLEEP && $past(mode) == MODE_SLEEP |-> !clk_gate_out) else $error("gate");
	a_off_gate_off: assert property (!controller_on_bit && !$past(controller_on_bit) |-> !clk_gate_out) else $error("gate");
	// cpu power states force power-down
	a_deep_stop_pd: assert property (cpu_mode == CPU_STOP12 && $past(cpu_mode) == CPU_STOP12 && !init_request
		&& $past(mode) != MODE_DISABLED |-> ##[0:2] mode == MODE_POWER_DOWN) else $error("no pd in stop");
	a_wait_stop_pd: assert property (cpu_mode == CPU_WAIT && wait_stop_select && $past(cpu_mode == CPU_WAIT && wait_stop_select)
		&& !init_request && $past(mode) != MODE_DISABLED |-> ##[0:2] mode == MODE_POWER_DOWN) else $error("no pd");
	// main scenarios reached
	c_sleep: cover property (mode == MODE_SLEEP);
	c_power_down: cover property (mode == MODE_POWER_DOWN);
	c_wake: cover property (wakeup_irq);
endmodule // can_mode_sva

// ### bench/test_can_mode_power_control.sv
// self-checking bench joining both ends of the can mode control
module test_can_mode_power_control
	import can_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0, wss = 1'b0, slp = 1'b0, wue = 1'b0, wie = 1'b0, ini = 1'b1, lsn = 1'b0, lpb = 1'b0;
	logic rxp = 1'b1, pend = 1'b0, ract = 1'b0, boff = 1'b0, txv = 1'b0;
	logic [1:0] cpu_md = CPU_RUN;
	logic [7:0] txd = 8'h00;
	logic txr, rxv, sak, iak, txp, gate, brd;
	logic [7:0] rxd;
	logic seen_low = 1'b0, seen_wk = 1'b0, seen_tx = 1'b0, seen_rx = 1'b0;
	int err_count = 0;
	int check_count = 0;
	can_link_if u_can_link_if ();
	can_mode_ctrl #(.BIT_DIV(8'h03)) u_can_mode_ctrl (.core_clk_in(core_clk), .rst_n_in(rst_n), .link(u_can_link_if.ctrl),
		.rx_pin_in(rxp), .tx_pin_out(txp), .tx_pending_in(pend), .rx_active_in(ract), .bus_off_in(boff),
		.clk_gate_out(gate), .busoff_run_done_out(brd));
	can_cpu_side u_can_cpu_side (.core_clk_in(core_clk), .rst_n_in(rst_n), .link(u_can_link_if.cpu), .enable_in(en),
		.wait_stop_select_in(wss), .sleep_req_in(slp), .wakeup_enable_in(wue), .wakeup_irq_enable_in(wie),
		.init_req_in(ini), .listen_only_in(lsn), .loopback_in(lpb), .cpu_mode_in(cpu_md), .tx_data_in(txd),
		.tx_valid_in(txv), .tx_ready_out(txr), .rx_data_out(rxd), .rx_valid_out(rxv), .sleep_ack_out(sak),
		.init_ack_out(iak));
	can_mode_sva u_can_mode_sva (.core_clk_in(core_clk), .rst_n_in(rst_n),
		.controller_on_bit(u_can_link_if.controller_on_bit), .wait_stop_select(u_can_link_if.wait_stop_select),
		.sleep_request(u_can_link_if.sleep_request), .sleep_ack(u_can_link_if.sleep_ack),
		.wakeup_enable(u_can_link_if.wakeup_enable), .wakeup_irq_enable(u_can_link_if.wakeup_irq_enable),
		.wakeup_irq(u_can_link_if.wakeup_irq), .init_request(u_can_link_if.init_request),
		.init_ack(u_can_link_if.init_ack), .listen_only(u_can_link_if.listen_only), .loopback(u_can_link_if.loopback),
		.cpu_mode(u_can_link_if.cpu_mode), .mode(u_can_link_if.mode), .tx_pin_out(txp), .clk_gate_out(gate));
	// core clock, 40 ns period
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	// latch pulses and any dominant level on the tx pin
	always @(posedge core_clk) begin
		if (txp === 1'b0) seen_low <= 1'b1;
		if (u_can_link_if.wakeup_irq === 1'b1) seen_wk <= 1'b1;
		if (u_can_link_if.tx_irq === 1'b1) seen_tx <= 1'b1;
		if (u_can_link_if.rx_irq === 1'b1) seen_rx <= 1'b1;
	end
	task automatic results();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic fail(input string msg);
		err_count++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	task automatic chk1(input logic got, input logic exp, input string msg);
		check_count++;
		if (got !== exp) fail(msg);
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		check_count++;
		if (got !== exp) fail(msg);
	endtask
	task automatic chkm(input can_mode_t exp, input string msg);
		check_count++;
		if (u_can_link_if.mode !== exp) fail(msg);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// bounded wait for a mode, ends the run on timeout
	task automatic wait_mode(input can_mode_t m, input int lim);
		for (int i = 0; i < lim && u_can_link_if.mode !== m; i++) tick(1);
		chkm(m, "mode wait timed out");
		if (u_can_link_if.mode !== m) results();
	endtask
	// hold valid until ready is seen at an edge
	task automatic push(input logic [7:0] d, input int lim, output bit ok);
		txd = d;
		txv = 1'b1;
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			ok = (u_can_link_if.tx_ready === 1'b1); // ready as the fifo sees it at the next edge
			tick(1);
		end
	endtask
	// enter init, set modes, leave through bus sync
	task automatic reconfig(input logic l, input logic b);
		ini = 1'b1;
		wait_mode(MODE_INIT, 20);
		tick(8);
		chk1(iak, 1'b1, "no init ack");
		chk1(txp, 1'b1, "tx active in init");
		lsn = l;
		lpb = b;
		ini = 1'b0;
		tick(30);
		chkm(MODE_WAKE_SYNC, "bus sync too short");
		wait_mode(MODE_NORMAL, 100);
	endtask
	// listen-only: words pile up, pin stays recessive
	task automatic listen_fill();
		int n;
		bit ok;
		n = 0;
		ok = 1'b1;
		seen_low = 1'b0;
		while (ok && n < 12) begin
			push(8'h10 + n[7:0], 30, ok);
			if (ok) n++;
		end
		txv = 1'b0;
		chk1(ok, 1'b0, "fifo never refused");
		chk1(n == FIFO_DEPTH, 1'b1, "fifo count wrong");
		chk1(txr, 1'b0, "ready while full");
		tick(100);
		chk1(seen_low, 1'b0, "dominant in listen");
	endtask
	// loopback: words return while rx pin is dominant
	task automatic loop_words();
		int n;
		bit ok;
		logic [7:0] got [3];
		reconfig(1'b0, 1'b1);
		rxp = 1'b0;
		seen_low = 1'b0;
		seen_tx = 1'b0;
		seen_rx = 1'b0;
		for (n = 0; n < 3; n++) push(8'ha0 + n[7:0], 30, ok);
		txv = 1'b0;
		n = 0;
		for (int i = 0; i < 3000 && n < 3; i++) begin
			if (rxv === 1'b1) begin
				got[n] = rxd;
				n++;
			end
			tick(1);
		end
		if (n < 3) begin
			fail("loopback words missing");
			results();
		end
		for (n = 0; n < 3; n++) chk8(got[n], 8'ha0 + n[7:0], "looped word");
		chk1(seen_low, 1'b0, "dominant in loopback");
		chk1(seen_tx & seen_rx, 1'b1, "missing irq");
		rxp = 1'b1;
		reconfig(1'b0, 1'b0);
		push(8'h00, 30, ok);
		txv = 1'b0;
		tick(200);
		chk1(seen_low, 1'b1, "no normal traffic");
	endtask
	// sleep request held off by tx then rx activity
	task automatic go_sleep(input logic we);
		wue = we;
		wie = we;
		pend = 1'b1;
		slp = 1'b1;
		tick(20);
		chkm(MODE_SLEEP_PEND, "slept with tx");
		pend = 1'b0;
		ract = 1'b1;
		slp = 1'b0;
		tick(20);
		chkm(MODE_SLEEP_PEND, "slept with rx");
		chk1(u_can_link_if.sleep_request, 1'b1, "early drop passed");
		slp = 1'b1;
		ract = 1'b0;
		wait_mode(MODE_SLEEP, 10);
		tick(3);
		chk1(sak, 1'b1, "no sleep ack");
		chk1(gate, 1'b0, "clocks run asleep");
		chk1(txp, 1'b1, "tx asleep");
	endtask
	// masked wake, paused bus-off count, cpu wake
	task automatic sleep_locked();
		boff = 1'b1;
		go_sleep(1'b0);
		tick(6000);
		chk1(brd, 1'b0, "count not paused");
		seen_wk = 1'b0;
		rxp = 1'b0;
		tick(40);
		chkm(MODE_SLEEP, "woke while masked");
		chk1(seen_wk, 1'b0, "irq while masked");
		cpu_md = CPU_STOP3;
		tick(5);
		chkm(MODE_SLEEP, "stop3 left sleep");
		cpu_md = CPU_RUN;
		rxp = 1'b1;
		slp = 1'b0;
		wait_mode(MODE_NORMAL, 200);
		for (int i = 0; i < 7000 && brd !== 1'b1; i++) tick(1);
		chk1(brd, 1'b1, "count not resumed");
		if (brd !== 1'b1) results();
		boff = 1'b0;
	endtask
	// bus activity wakes, sync waits for recessive bits
	task automatic sleep_wake();
		go_sleep(1'b1);
		seen_wk = 1'b0;
		rxp = 1'b0;
		wait_mode(MODE_WAKE_SYNC, 20);
		slp = 1'b0; // drop while sleep_ack still stands
		tick(2);
		chk1(seen_wk, 1'b1, "no wake irq");
		tick(18);
		chkm(MODE_WAKE_SYNC, "synced on dominant");
		rxp = 1'b1;
		wait_mode(MODE_NORMAL, 200);
	endtask
	// cpu power state table
	task automatic power_modes();
		logic [1:0] cm [4] = '{CPU_WAIT, CPU_WAIT, CPU_STOP3, CPU_STOP12};
		logic ws [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		logic pd [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
		for (int k = 0; k < 4; k++) begin
			wss = ws[k];
			cpu_md = cm[k];
			tick(4);
			chkm(pd[k] ? MODE_POWER_DOWN : MODE_NORMAL, "cpu mode map");
			chk1(txp, 1'b1, "tx in power-down");
			cpu_md = CPU_RUN;
			if (pd[k]) wait_mode(MODE_RECOVER, 6);
			wait_mode(MODE_NORMAL, 100);
		end
		wss = 1'b0;
	endtask
	// main sequence
	initial begin
		tick(2);
		rst_n = 1'b1;
		en = 1'b1;
		reconfig(1'b1, 1'b0);
		listen_fill();
		loop_words();
		sleep_locked();
		sleep_wake();
		power_modes();
		results();
	end
endmodule // test_can_mode_power_control
